// file: rtl/efr_ext_flash_readout.sv
`include "efr_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module efr_ext_flash_readout #(
  parameter int ADDR_W = 24
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sampling tick and fetch engine
  input wire logic fs_tick,
  input wire logic [2:0] ch_last,
  input wire logic [ADDR_W-1:0] audio_cur_addr,
  input wire logic [ADDR_W-1:0] audio_stop_addr,
  input wire logic playback_status_evt,
  output logic [2:0] fetch_req,
  output logic [2:0] ch_load,
  output logic [2:0] read_active,
  // Playback mode
  output logic continuous_play_mode,
  output logic silent_play_mode,
  // Interrupt
  output logic irq
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  generate
    if (ADDR_W < 6 || ADDR_W > 32) begin : g_bad_addr_w
      $error("ADDR_W must lie between 6 and 32");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  efr_pkg::efr_ch_state_t st_r [3];
  logic [2:0] fetch_req_r;
  logic [2:0] ch_load_r;
  logic [1:0] mode_r;
  efr_pkg::efr_thr_sel_t thr_sel_r;
  logic [4:0] ie_r;
  logic [4:0] flags_r;
  logic [4:0] flags_nxt;
  logic [4:0] flag_set;
  logic [4:0] flag_clr;
  logic thr_hit;
  logic thr_hit_r;
  logic thr_set;
  logic [ADDR_W-1:0] remain;
  logic [ADDR_W-1:0] thr_level;
  logic irq_r;
  logic [31:0] prdata_r;
  logic err_r;
  logic [15:0] rd_idx;
  logic [15:0] acc_idx;
  logic idx_ok;
  logic aligned;
  logic setup;
  logic wr_acc;
  logic lane_lo;
  logic lane_hi;
  logic wr_ctrl;
  logic wr_thr;
  logic wr_ie;
  logic wr_clr;
  logic wr_mode;
  logic [2:0] start_wr;
  logic [2:0] stop_wr;
  logic [2:0] done_set;
  logic reissue;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pwrite;
  assign acc_idx = paddr[17:2];
  assign rd_idx = paddr[17:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign lane_lo = pstrb[0];
  assign lane_hi = pstrb[1];

  always_comb begin
    idx_ok = 1'b0;
    case (rd_idx)
      `EFR_IDX_MODE: idx_ok = aligned;
      `EFR_IDX_CTRL: idx_ok = aligned;
      `EFR_IDX_THR: idx_ok = aligned;
      `EFR_IDX_IE: idx_ok = aligned;
      `EFR_IDX_STAT: idx_ok = aligned;
      `EFR_IDX_CLR: idx_ok = aligned;
      default: idx_ok = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Write strobes
  // ----------------------------------------------------------------
  assign wr_mode = wr_acc & aligned & (acc_idx == `EFR_IDX_MODE);
  assign wr_ctrl = wr_acc & aligned & (acc_idx == `EFR_IDX_CTRL);
  assign wr_thr = wr_acc & aligned & (acc_idx == `EFR_IDX_THR);
  assign wr_ie = wr_acc & aligned & (acc_idx == `EFR_IDX_IE);
  assign wr_clr = wr_acc & aligned & (acc_idx == `EFR_IDX_CLR);

  // Only ones count on start bits; stop bits are the clear path
  assign start_wr = (wr_ctrl & lane_lo) ?
                    pwdata[`EFR_CTRL_START_LSB +: 3] : 3'h0;
  assign stop_wr = (wr_ctrl & lane_hi) ?
                   pwdata[`EFR_CTRL_STOP_LSB +: 3] : 3'h0;
  assign flag_clr = (wr_clr & lane_lo) ? pwdata[4:0] : 5'h00;
  assign reissue = wr_clr & lane_hi & pwdata[`EFR_CLR_REISSUE_BIT];

  // ----------------------------------------------------------------
  // Read data and response, sampled in the setup cycle
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      err_r <= 1'b0;
    end else if (setup) begin
      err_r <= ~idx_ok;
      prdata_r <= 32'h0000_0000;
      if (!pwrite && idx_ok) begin
        case (rd_idx)
          `EFR_IDX_MODE: prdata_r <= {30'h0, mode_r};
          `EFR_IDX_CTRL: prdata_r <= {29'h0, read_active};
          `EFR_IDX_THR: prdata_r <= {30'h0, thr_sel_r};
          `EFR_IDX_IE: prdata_r <= {27'h0, ie_r};
          `EFR_IDX_STAT: prdata_r <= {27'h0, flags_r};
          default: prdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = psel & penable & err_r;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= `EFR_MODE_RST;
    end else if (wr_mode && lane_lo) begin
      mode_r <= pwdata[1:0];
    end
  end

  // ----------------------------------------------------------------
  // Mode outputs, threshold select and interrupt enable registers
  // ----------------------------------------------------------------
  assign continuous_play_mode = mode_r[`EFR_MODE_CONT_BIT];
  assign silent_play_mode = mode_r[`EFR_MODE_SILENT_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thr_sel_r <= `EFR_THR_RST;
    end else if (wr_thr && lane_lo) begin
      thr_sel_r <= pwdata[`EFR_THR_SEL_LSB +: 2];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ie_r <= `EFR_IE_RST;
    end else if (wr_ie && lane_lo) begin
      ie_r <= pwdata[4:0];
    end
  end

  // ----------------------------------------------------------------
  // Readout channels
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 3; i++) begin
        st_r[i] <= efr_pkg::CH_IDLE;
      end
      fetch_req_r <= 3'h0;
      ch_load_r <= 3'h0;
    end else begin
      fetch_req_r <= 3'h0;
      ch_load_r <= 3'h0;
      for (int i = 0; i < 3; i++) begin
        case (st_r[i])
          efr_pkg::CH_IDLE: begin
            if (start_wr[i] && !stop_wr[i]) begin
              st_r[i] <= efr_pkg::CH_PEND;
            end
          end
          efr_pkg::CH_PEND: begin
            if (stop_wr[i]) begin
              st_r[i] <= efr_pkg::CH_IDLE;
            end else if (fs_tick) begin
              st_r[i] <= efr_pkg::CH_ACT;
              ch_load_r[i] <= 1'b1;
              fetch_req_r[i] <= 1'b1;
            end
          end
          efr_pkg::CH_ACT: begin
            if (stop_wr[i]) begin
              st_r[i] <= efr_pkg::CH_STOP;
            end else if (ch_last[i]) begin
              if (i == 0 && continuous_play_mode) begin
                ch_load_r[i] <= 1'b1;
              end else begin
                st_r[i] <= efr_pkg::CH_IDLE;
              end
            end else if (fs_tick) begin
              fetch_req_r[i] <= 1'b1;
            end
          end
          efr_pkg::CH_STOP: begin
            if (fs_tick) begin
              st_r[i] <= efr_pkg::CH_IDLE;
            end
          end
          default: begin
            st_r[i] <= efr_pkg::CH_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Channel status
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      read_active[i] = (st_r[i] != efr_pkg::CH_IDLE);
      done_set[i] = (st_r[i] == efr_pkg::CH_ACT) & ch_last[i] & ~stop_wr[i];
    end
  end

  assign fetch_req = fetch_req_r;
  assign ch_load = ch_load_r;

  // ----------------------------------------------------------------
  // Near-end threshold
  // ----------------------------------------------------------------
  always_comb begin
    case (thr_sel_r)
      2'h1: thr_level = ADDR_W'(`EFR_THR_BYTES_SEL1);
      2'h2: thr_level = ADDR_W'(`EFR_THR_BYTES_SEL2);
      2'h3: thr_level = ADDR_W'(`EFR_THR_BYTES_SEL3);
      default: thr_level = '0;
    endcase
  end

  // ----------------------------------------------------------------
  // Remaining bytes to stop address
  // ----------------------------------------------------------------
  assign remain = audio_stop_addr - audio_cur_addr;
  assign thr_hit = (st_r[0] == efr_pkg::CH_ACT) &
                   (audio_stop_addr >= audio_cur_addr) &
                   (remain <= thr_level);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thr_hit_r <= 1'b0;
    end else begin
      thr_hit_r <= thr_hit;
    end
  end

  // ----------------------------------------------------------------
  // Threshold flag source
  // ----------------------------------------------------------------
  assign thr_set = (thr_sel_r == 2'h0) ? done_set[0] :
                   (thr_hit & ~thr_hit_r);

  // ----------------------------------------------------------------
  // Status flags, set wins over clear
  // ----------------------------------------------------------------
  assign flag_set[`EFR_FLAG_AUDIO] = done_set[0];
  assign flag_set[`EFR_FLAG_EVENT] = done_set[1];
  assign flag_set[`EFR_FLAG_EDIT] = done_set[2];
  assign flag_set[`EFR_FLAG_THR] = thr_set;
  assign flag_set[`EFR_FLAG_PLAY] = playback_status_evt;
  assign flags_nxt = (flags_r & ~flag_clr) | flag_set;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_r <= `EFR_STAT_RST;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt request, re-issue drops it for one cycle
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= (|(flags_nxt & ie_r)) & ~reissue;
    end
  end

  assign irq = irq_r;

endmodule

`default_nettype wire

// file: rtl/efr_defines.svh
`ifndef EFR_DEFINES_SVH
`define EFR_DEFINES_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define EFR_IDX_MODE 16'hfa18
`define EFR_IDX_CTRL 16'hfa1a
`define EFR_IDX_THR 16'hfa1c
`define EFR_IDX_IE 16'hfa1e
`define EFR_IDX_STAT 16'hfa20
`define EFR_IDX_CLR 16'hfa22

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define EFR_CTRL_START_LSB 0
`define EFR_CTRL_STOP_LSB 8
`define EFR_MODE_SILENT_BIT 0
`define EFR_MODE_CONT_BIT 1
`define EFR_THR_SEL_LSB 0
`define EFR_FLAG_AUDIO 0
`define EFR_FLAG_EVENT 1
`define EFR_FLAG_EDIT 2
`define EFR_FLAG_THR 3
`define EFR_FLAG_PLAY 4
`define EFR_CLR_REISSUE_BIT 15

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define EFR_CTRL_RST 3'h0
`define EFR_THR_RST 2'h0
`define EFR_IE_RST 5'h10
`define EFR_STAT_RST 5'h00
`define EFR_MODE_RST 2'h0

// ----------------------------------------------------------------
// Near-end threshold levels in bytes
// ----------------------------------------------------------------
`define EFR_THR_BYTES_SEL1 8
`define EFR_THR_BYTES_SEL2 16
`define EFR_THR_BYTES_SEL3 32

`endif

// file: rtl/efr_pkg.sv
package efr_pkg;

  // Readout channel state
  typedef enum logic [1:0] {
    CH_IDLE,
    CH_PEND,
    CH_ACT,
    CH_STOP
  } efr_ch_state_t;

  // Near-end threshold selection
  typedef logic [1:0] efr_thr_sel_t;

endpackage

// file: verification/efr_checker.sv
`include "efr_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module efr_checker (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // Channels
  input wire logic fs_tick,
  input wire logic [2:0] fetch_req,
  input wire logic [2:0] ch_load,
  input wire logic [2:0] read_active,
  input wire logic continuous_play_mode,
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic wr_ctrl;
  assign acc = psel && penable;
  assign wr_ctrl = acc && pwrite && paddr == {`EFR_IDX_CTRL, 2'h0} && pstrb[0];
  sequence s_ev_start;
    wr_ctrl && pwdata[1] && !(pwdata[9] && pstrb[1]) && !read_active[1];
  endsequence
  sequence s_ie_off;
    acc && pwrite && paddr == {`EFR_IDX_IE, 2'h0} && pstrb[0] &&
      pwdata[4:0] == 5'h00;
  endsequence
  property p_ev_start;
    s_ev_start |=> read_active[1];
  endproperty
  a_ev_start: assert property (p_ev_start) else $error("no start");
  property p_zero_wr;
    wr_ctrl && !pwdata[2] && !read_active[2] |=> !read_active[2];
  endproperty
  a_zero_wr: assert property (p_zero_wr) else $error("zero set");
  property p_fetch_tick;
    |fetch_req |-> $past(fs_tick);
  endproperty
  a_fetch_tick: assert property (p_fetch_tick) else $error("no tick");
  property p_fetch_act;
    fetch_req[0] |-> $past(read_active[0]);
  endproperty
  a_fetch_act: assert property (p_fetch_act) else $error("idle fetch");
  property p_load_fetch;
    ch_load[2] |-> fetch_req[2];
  endproperty
  a_load_fetch: assert property (p_load_fetch) else $error("no fetch");
  property p_sync;
    ch_load[1] |-> $past(fs_tick) && $past(read_active[1]);
  endproperty
  a_sync: assert property (p_sync) else $error("unsynced");
  property p_ctrl_rd;
    acc && !pwrite && paddr == {`EFR_IDX_CTRL, 2'h0} |-> prdata[31:3] == 0;
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("ctrl bits");
  property p_clr_rd;
    acc && !pwrite && paddr == {`EFR_IDX_CLR, 2'h0} |-> prdata == 0;
  endproperty
  a_clr_rd: assert property (p_clr_rd) else $error("clr read");
  property p_unmapped;
    acc && paddr == {16'hfa24, 2'h0} |-> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("no error");
  property p_mode;
    acc && pwrite && paddr == {`EFR_IDX_MODE, 2'h0} && pstrb[0]
      |=> continuous_play_mode == $past(pwdata[1]);
  endproperty
  a_mode: assert property (p_mode) else $error("mode bit");
  property p_ie_off;
    s_ie_off |=> ##1 !irq;
  endproperty
  a_ie_off: assert property (p_ie_off) else $error("irq unmasked");
endmodule
bind efr_ext_flash_readout efr_checker u_chk (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pslverr, .fs_tick,
  .fetch_req, .ch_load, .read_active, .continuous_play_mode, .irq);
`default_nettype wire

// file: verification/efr_flash_model.sv
`timescale 1ns/1ns
`default_nettype none
module efr_flash_model #(
  parameter int ADDR_W = 24,
  parameter int N_AUD = 4
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Requests
  input wire logic [2:0] fetch_req,
  input wire logic [2:0] ch_load,
  // Answers
  output logic [2:0] ch_last,
  output logic [ADDR_W-1:0] audio_cur_addr,
  output logic [ADDR_W-1:0] audio_stop_addr
);
  localparam logic [ADDR_W-1:0] BASE = 'h100;
  int left_r [3];
  int n;
  assign audio_stop_addr = BASE + ADDR_W'(8 * (N_AUD - 1));
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch_last <= '0;
      audio_cur_addr <= BASE;
      left_r <= '{0, 0, 0};
    end else begin
      for (int k = 0; k < 3; k++) begin
        n = ch_load[k] ? ((k == 0) ? N_AUD : 1) : left_r[k];
        ch_last[k] <= fetch_req[k] && n == 1;
        left_r[k] <= fetch_req[k] ? n - 1 : n;
      end
      audio_cur_addr <= (ch_load[0] ? BASE : audio_cur_addr)
        + (fetch_req[0] ? ADDR_W'(8) : ADDR_W'(0));
    end
  end
endmodule
`default_nettype wire

// file: verification/efr_ext_flash_readout_tb.sv
`include "efr_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module efr_ext_flash_readout_tb;
  typedef struct {
    logic [15:0] i;
    logic [31:0] d;
    logic [31:0] q;
    logic e;
  } efr_row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e;
  logic fs_tick, playback_status_evt, tick_en, continuous_play_mode;
  logic silent_play_mode;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0] pstrb;
  logic [2:0] ch_last, fetch_req, ch_load, read_active;
  logic [23:0] audio_cur_addr, audio_stop_addr;
  int err_total, num_checks, tcnt;
  efr_row_t rows [6];
  efr_ext_flash_readout dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .fs_tick,
    .ch_last, .audio_cur_addr, .audio_stop_addr, .playback_status_evt,
    .fetch_req, .ch_load, .read_active, .continuous_play_mode,
    .silent_play_mode, .irq);
  efr_flash_model model (.pclk, .presetn, .fetch_req, .ch_load, .ch_last,
    .audio_cur_addr, .audio_stop_addr);
  initial begin
    pclk = 0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    tcnt <= (tcnt == 5) ? 0 : tcnt + 1;
    fs_tick <= tick_en && tcnt == 5;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [15:0] i,
                     input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'h0};
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk(32'(pready), 32'h1);
    if (pready !== 1'b1) give_verdict();
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [15:0] i, input logic [31:0] q);
    apb(1'b0, i, 32'h0);
    chk(r, q);
  endtask
  function automatic logic pick(input int w);
    case (w)
      3: pick = irq;
      7: pick = ch_last[0];
      default: pick = (w < 3) ? read_active[w] : fetch_req[w - 4];
    endcase
  endfunction
  task automatic wt(input int w, input logic v);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pick(w) !== v && n < 200);
    chk(32'(pick(w)), 32'(v));
    if (pick(w) !== v) give_verdict();
  endtask
  task automatic reset_dut();
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, playback_status_evt} = '0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hf;
    tick_en = 1'b1;
    presetn = 1'b0;
    err_total = 0;
    num_checks = 0;
    rows = '{'{`EFR_IDX_THR, 32'hff, 32'h3, 1'b0},
             '{`EFR_IDX_IE, 32'hff, 32'h1f, 1'b0},
             '{`EFR_IDX_STAT, 32'hff, 32'h0, 1'b0},
             '{`EFR_IDX_CLR, 32'hffff, 32'h0, 1'b0},
             '{`EFR_IDX_MODE, 32'hff, 32'h3, 1'b0},
             '{16'hfa24, 32'h1, 32'h0, 1'b1}};
    reset_dut();
    foreach (rows[k]) begin
      apb(1'b1, rows[k].i, rows[k].d);
      rd(rows[k].i, rows[k].q);
      chk(32'(e), 32'(rows[k].e));
    end
    chk(32'({continuous_play_mode, silent_play_mode}), 32'h3);
    $display("register table done");
    reset_dut();
    rd(`EFR_IDX_IE, 32'h10);
    rd(`EFR_IDX_CTRL, 32'h0);
    rd(`EFR_IDX_THR, 32'h0);
    chk(32'({continuous_play_mode, silent_play_mode}), 32'h0);
    playback_status_evt <= 1'b1;
    @(posedge pclk) playback_status_evt <= 1'b0;
    rd(`EFR_IDX_STAT, 32'h10);
    wt(3, 1'b1);
    apb(1'b1, `EFR_IDX_CLR, 32'h8000);
    chk(32'(irq), 32'h0);
    wt(3, 1'b1);
    apb(1'b1, `EFR_IDX_IE, 32'h0);
    wt(3, 1'b0);
    apb(1'b1, `EFR_IDX_CLR, 32'h0f);
    rd(`EFR_IDX_STAT, 32'h10);
    apb(1'b1, `EFR_IDX_CLR, 32'h10);
    rd(`EFR_IDX_STAT, 32'h0);
    $display("reset and flags done");
    tick_en <= 1'b0;
    apb(1'b1, `EFR_IDX_CTRL, 32'h0);
    chk(32'(read_active), 32'h0);
    apb(1'b1, `EFR_IDX_CTRL, 32'h4);
    chk(32'(read_active), 32'h4);
    repeat (5) apb(1'b1, `EFR_IDX_CTRL, 32'h400);
    chk(32'(read_active), 32'h0);
    tick_en <= 1'b1;
    repeat (8) @(posedge pclk);
    chk(32'(fetch_req | read_active), 32'h0);
    $display("cancel done");
    apb(1'b1, `EFR_IDX_IE, 32'h7);
    for (int k = 1; k < 3; k++) begin
      apb(1'b1, `EFR_IDX_CTRL, 32'(1 << k));
      wt(4 + k, 1'b1);
      wt(k, 1'b0);
      rd(`EFR_IDX_STAT, 32'(1 << k));
      wt(3, 1'b1);
      apb(1'b1, `EFR_IDX_CLR, 32'(1 << k));
      rd(`EFR_IDX_STAT, 32'h0);
    end
    $display("event and edit done");
    apb(1'b1, `EFR_IDX_CTRL, 32'h1);
    wt(4, 1'b1);
    apb(1'b1, `EFR_IDX_CTRL, 32'h100);
    wt(0, 1'b0);
    rd(`EFR_IDX_STAT, 32'h0);
    apb(1'b1, `EFR_IDX_THR, 32'h1);
    apb(1'b1, `EFR_IDX_MODE, 32'h2);
    chk(32'({continuous_play_mode, silent_play_mode}), 32'h2);
    apb(1'b1, `EFR_IDX_CTRL, 32'h1);
    wt(7, 1'b1);
    repeat (2) @(posedge pclk);
    chk(32'(read_active[0]), 32'h1);
    rd(`EFR_IDX_STAT, 32'h9);
    apb(1'b1, `EFR_IDX_THR, 32'h3);
    apb(1'b1, `EFR_IDX_CLR, 32'h9);
    wt(7, 1'b1);
    repeat (2) @(posedge pclk);
    rd(`EFR_IDX_STAT, 32'h9);
    apb(1'b1, `EFR_IDX_MODE, 32'h0);
    wt(0, 1'b0);
    $display("audio done");
    give_verdict();
  end
endmodule
`default_nettype wire
